// ==== design/t1d_config_bank.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - E1 after reset; T1 defaults after settle
// - reset pin low 10 us clears everything
// - system interface configs default to zero
// - loop-backs disabled, loop config zero
// - framing mode registers default to zero
// - clock and time-slot offsets: CFG0 registers cleared, CFG1 registers reset 9Ch
// - idle code zero, no idle channels
// - no clear channels by default
// - line interface and LOS counts zero
// - pulse mask 40h 03h 7Bh, transmitter off
// - all six interrupt masks reset FFh
// - internal second timer, powered on
// - recovered clock from DPLL, attenuator internal
// - system clocks and sync pins selected
// - one-second port input, active high
// - multifunction ports default to sync-pulse inputs
// - multiframe sync active low, polarity programmable
// - multiframe sync enabled via port function field
// - signaling controller modes reset to zero
// - address compare FDh FFh, FFh FFh
// - time-slot selectors reset to zero
module t1d_config_bank
   import t1d_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // reset pin
   input wire logic hwResetInN,
   // configuration write port
   input wire logic wrEn,
   input wire logic [t1d_pkg::IDX_W-1:0] wrIdx,
   input wire logic [7:0] wrData,
   // configuration read port
   input wire logic [t1d_pkg::IDX_W-1:0] rdIdx,
   output logic [7:0] rdData,
   // whole bank
   output t1d_pkg::t1d_bank_t cfgBank,
   // mode status
   output logic t1Active,
   output logic settling,
   output logic inPinReset,
   output logic outputsEnabled,
   output logic txLineHighZ,
   // transmit multifunction port pins
   input wire logic [t1d_pkg::NUM_MF_PORTS-1:0] txMfPortIn,
   // multiframe sync status
   output logic mfSyncEnabled,
   output logic [1:0] mfSyncPort,
   output logic mfSyncDetect,
   output logic polarityMisuse,
   output logic syncPortConflict
);
   import t1d_pkg::*;

   typedef struct packed {
      t1d_bank_t bank;
      logic [7:0] rd;
      logic [NUM_MF_PORTS-1:0] pinSync1;
      logic [NUM_MF_PORTS-1:0] pinSync2;
      logic mfEn;
      logic [1:0] mfPort;
      logic mfDet;
      logic polBad;
      logic conflict;
      logic outEn;
      logic highZ;
   } t1d_core_state_t;

   t1d_core_state_t s_r, s_nxt;
   t1d_ctl_if ctl ();

   t1d_reset_qual uQual (
      .clock(clock),
      .rst(rst),
      .hwResetInN(hwResetInN),
      .ctl(ctl.rq)
   );

   t1d_mode_settle uSettle (
      .clock(clock),
      .rst(rst),
      .ctl(ctl.ms)
   );

   assign ctl.modeSelect = s_r.bank[REG_FRAMING_MODE1][MODE_SELECT_BIT];

   always_comb begin
      logic en;
      logic sypxElsewhere;
      logic [1:0] port;
      logic pol;
      logic [3:0] fn;
      en = 1'b0;
      sypxElsewhere = 1'b0;
      port = 2'b00;
      pol = 1'b0;
      fn = 4'h0;
      s_nxt = s_r;
      s_nxt.pinSync1 = txMfPortIn;
      s_nxt.pinSync2 = s_r.pinSync1;

      if (ctl.pinResetActive) begin
         // a held pin reset returns the whole bank, mode select included
         s_nxt.bank = BANK_RESET;
      end else if (ctl.loadDefaults) begin
         // T1 defaults; the mode select bit that caused this is kept
         s_nxt.bank = BANK_RESET;
         s_nxt.bank[REG_TX_PULSE_MASK + 2] = RST_PULSE_MASK2;
         s_nxt.bank[REG_GENERAL_PORT_CFG] = RST_ZERO;
         s_nxt.bank[REG_FRAMING_MODE1] = s_r.bank[REG_FRAMING_MODE1];
      end else if (wrEn && !ctl.settling && wrIdx < IDX_W'(NREG)) begin
         // writes while clocking settles would be overwritten, so they are dropped
         s_nxt.bank[wrIdx] = wrData;
      end

      s_nxt.rd = (rdIdx < IDX_W'(NREG)) ? s_r.bank[rdIdx] : RST_ZERO;

      // multifunction port scan; lowest port wins if several carry the function
      for (int i = NUM_MF_PORTS - 1; i >= 0; i--) begin
         fn = s_r.bank[REG_MULTIFUNCTION_PORT_CFG + i][3:0];
         if (fn == XPC_FN_MFSYNC) begin
            en = 1'b1;
            port = 2'(i);
         end
      end
      for (int i = 0; i < NUM_MF_PORTS; i++) begin
         fn = s_r.bank[REG_MULTIFUNCTION_PORT_CFG + i][3:0];
         if (fn == XPC_FN_TX_SYNC_PULSE && 2'(i) != port) begin
            sypxElsewhere = 1'b1;
         end
      end
      pol = s_r.bank[REG_PORT_CFG5][MFSYNC_POL_BIT];
      s_nxt.mfEn = en;
      s_nxt.mfPort = port;
      // default polarity is active low
      s_nxt.mfDet = en && (pol ? s_r.pinSync2[port] : !s_r.pinSync2[port]);
      s_nxt.polBad = pol && !en;
      s_nxt.conflict = en && sypxElsewhere;
      s_nxt.outEn = !ctl.pinResetActive;
      s_nxt.highZ = ctl.pinResetActive || s_r.bank[REG_TX_PULSE_MASK + 2][LINE_HIGHZ_BIT];
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_r <= '{bank: BANK_RESET, rd: 8'h00, pinSync1: '0, pinSync2: '0, mfEn: 1'b0, mfPort: 2'b00,
                  mfDet: 1'b0, polBad: 1'b0, conflict: 1'b0, outEn: 1'b0, highZ: 1'b1};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdData = s_r.rd;
   assign cfgBank = s_r.bank;
   assign t1Active = ctl.t1Active;
   assign settling = ctl.settling;
   assign inPinReset = ctl.pinResetActive;
   assign outputsEnabled = s_r.outEn;
   assign txLineHighZ = s_r.highZ;
   assign mfSyncEnabled = s_r.mfEn;
   assign mfSyncPort = s_r.mfPort;
   assign mfSyncDetect = s_r.mfDet;
   assign polarityMisuse = s_r.polBad;
   assign syncPortConflict = s_r.conflict;

   irqMaskDefault_a: assert property (@(posedge clock) disable iff (rst)
      ctl.loadDefaults |=> s_r.bank[REG_IRQ_MASK_REGS] == RST_IRQ_MASK &&
         s_r.bank[REG_IRQ_MASK_REGS + NUM_IRQ_MASK - 1] == RST_IRQ_MASK)
      else $error("interrupt masks not FFh after defaults");

   pulseMaskDefault_a: assert property (@(posedge clock) disable iff (rst)
      ctl.pinResetActive |=> s_r.bank[REG_TX_PULSE_MASK] == RST_PULSE_MASK0 &&
         s_r.bank[REG_TX_PULSE_MASK + 1] == RST_PULSE_MASK1 && s_r.bank[REG_TX_PULSE_MASK + 2] == RST_PULSE_MASK2
         ##1 txLineHighZ)
      else $error("pulse mask defaults or line high impedance wrong");

   addrCompare_a: assert property (@(posedge clock) disable iff (rst)
      ctl.loadDefaults |=> s_r.bank[REG_RX_ADDR_COMPARE_HIGH] == RST_ADDR_HIGH1 &&
         s_r.bank[REG_RX_ADDR_COMPARE_LOW + 1] == RST_ADDR_LOW && s_r.bank[REG_TX_OFFSET_CFG0] == RST_ZERO)
      else $error("address compare or offset defaults wrong");

   settleWrite_a: assert property (@(posedge clock) disable iff (rst)
      ctl.settling && !ctl.loadDefaults && !ctl.pinResetActive |=> s_r.bank == $past(s_r.bank))
      else $error("bank changed while clocking settles");

   outputFloat_a: assert property (@(posedge clock) disable iff (rst)
      ctl.pinResetActive [*2] |-> !outputsEnabled && txLineHighZ && !ctl.t1Active)
      else $error("outputs driven during pin reset");

   polMisuse_a: assert property (@(posedge clock) disable iff (rst)
      s_r.bank[REG_PORT_CFG5][MFSYNC_POL_BIT] && !mfSyncEnabled ##1 $stable(s_r.bank) && !mfSyncEnabled
         |-> polarityMisuse)
      else $error("polarity misuse not flagged");

   syncConflict_a: assert property (@(posedge clock) disable iff (rst)
      syncPortConflict |-> mfSyncEnabled)
      else $error("conflict flagged without multiframe sync");

endmodule

// ==== design/t1d_pkg.sv ====
package t1d_pkg;

   // timing
   localparam int CLK_MHZ = 50;
   localparam int RESET_MIN_NS = 10000;
   localparam int RESET_MIN_CYC = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int SETTLE_MAX_NS = 20000;
   localparam int SETTLE_CYC = (SETTLE_MAX_NS * CLK_MHZ) / 1000;

   // register indices
   localparam int IDX_W = 6;
   localparam int NREG = 58;
   localparam int REG_SYS_IF_CFG1 = 0;
   localparam int REG_SYS_IF_CFG2 = 1;
   localparam int REG_SYS_IF_CFG3 = 2;
   localparam int REG_LOOP_CFG = 3;
   localparam int REG_FRAMING_MODE4 = 4;
   localparam int REG_FRAMING_MODE5 = 5;
   localparam int REG_TX_OFFSET_CFG0 = 6;
   localparam int REG_TX_OFFSET_CFG1 = 7;
   localparam int REG_RX_OFFSET_CFG0 = 8;
   localparam int REG_RX_OFFSET_CFG1 = 9;
   localparam int REG_IDLE_CODE = 10;
   localparam int REG_IDLE_CHANNEL_SELECT = 11;
   localparam int REG_CLEAR_CHANNEL_SELECT = 14;
   localparam int REG_LINE_IF_MODE0 = 17;
   localparam int REG_LINE_IF_MODE1 = 18;
   localparam int REG_LOS_DETECT_COUNT = 19;
   localparam int REG_LOS_RECOVER_COUNT = 20;
   localparam int REG_TX_PULSE_MASK = 21;
   localparam int REG_IRQ_MASK_REGS = 24;
   localparam int NUM_IRQ_MASK = 6;
   localparam int REG_GLOBAL_CFG = 30;
   localparam int REG_CLOCK_MODE1 = 31;
   localparam int REG_CLOCK_SIGNALING_A = 32;
   localparam int REG_GENERAL_PORT_CFG = 33;
   localparam int REG_MULTIFUNCTION_PORT_CFG = 34;
   localparam int NUM_MF_PORTS = 4;
   localparam int REG_PORT_CFG5 = 38;
   localparam int REG_PORT_CFG6 = 39;
   localparam int REG_SIGNALING_MODE = 40;
   localparam int REG_SIGNALING_A = 41;
   localparam int REG_SIGNALING_B = 42;
   localparam int REG_RX_ADDR_COMPARE_HIGH = 43;
   localparam int REG_RX_ADDR_COMPARE_LOW = 45;
   localparam int REG_RX_TIMESLOT_SELECT = 47;
   localparam int REG_TX_TIMESLOT_SELECT = 51;
   localparam int REG_SIG_CH2_TIMESLOT = 55;
   localparam int REG_SIG_CH3_TIMESLOT = 56;
   localparam int REG_FRAMING_MODE1 = 57;

   // fields
   localparam int MODE_SELECT_BIT = 0;
   localparam int LINE_HIGHZ_BIT = 6;
   localparam int MFSYNC_POL_BIT = 0;
   localparam logic [3:0] XPC_FN_TX_SYNC_PULSE = 4'h0;
   localparam logic [3:0] XPC_FN_MFSYNC = 4'h1;

   // reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_OFFSET_CFG1 = 8'h9C;
   localparam logic [7:0] RST_PULSE_MASK0 = 8'h40;
   localparam logic [7:0] RST_PULSE_MASK1 = 8'h03;
   localparam logic [7:0] RST_PULSE_MASK2 = 8'h7B;
   localparam logic [7:0] RST_IRQ_MASK = 8'hFF;
   localparam logic [7:0] RST_ADDR_HIGH1 = 8'hFD;
   localparam logic [7:0] RST_ADDR_HIGH2 = 8'hFF;
   localparam logic [7:0] RST_ADDR_LOW = 8'hFF;

   typedef logic [NREG-1:0][7:0] t1d_bank_t;

   function automatic t1d_bank_t t1dDefaults();
      t1d_bank_t b;
      b = '0;
      for (int i = 0; i < NREG; i++) begin
         b[i] = RST_ZERO;
      end
      b[REG_TX_OFFSET_CFG1] = RST_OFFSET_CFG1;
      b[REG_RX_OFFSET_CFG1] = RST_OFFSET_CFG1;
      b[REG_TX_PULSE_MASK] = RST_PULSE_MASK0;
      b[REG_TX_PULSE_MASK + 1] = RST_PULSE_MASK1;
      b[REG_TX_PULSE_MASK + 2] = RST_PULSE_MASK2;
      for (int i = 0; i < NUM_IRQ_MASK; i++) begin
         b[REG_IRQ_MASK_REGS + i] = RST_IRQ_MASK;
      end
      b[REG_RX_ADDR_COMPARE_HIGH] = RST_ADDR_HIGH1;
      b[REG_RX_ADDR_COMPARE_HIGH + 1] = RST_ADDR_HIGH2;
      b[REG_RX_ADDR_COMPARE_LOW] = RST_ADDR_LOW;
      b[REG_RX_ADDR_COMPARE_LOW + 1] = RST_ADDR_LOW;
      return b;
   endfunction

   localparam t1d_bank_t BANK_RESET = t1dDefaults();

endpackage

// ==== design/t1d_ctl_if.sv ====
`timescale 1ns/1ps
interface t1d_ctl_if;
   logic pinResetActive;
   logic modeSelect;
   logic t1Active;
   logic settling;
   logic loadDefaults;
   modport rq (output pinResetActive);
   modport ms (input modeSelect, input pinResetActive, output t1Active, output settling, output loadDefaults);
   modport core (input pinResetActive, input t1Active, input settling, input loadDefaults, output modeSelect);
endinterface

// ==== design/t1d_reset_qual.sv ====
`timescale 1ns/1ps
module t1d_reset_qual
   import t1d_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // reset pin
   input wire logic hwResetInN,
   // to core
   t1d_ctl_if.rq ctl
);
   import t1d_pkg::*;

   localparam int CW = $clog2(RESET_MIN_CYC + 1);

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic [CW-1:0] lowCnt;
      logic active;
   } t1d_rq_state_t;

   t1d_rq_state_t s_r, s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.sync1 = hwResetInN;
      s_nxt.sync2 = s_r.sync1;
      // short glitches are ignored; only a sustained low resets the bank
      if (s_r.sync2) begin
         s_nxt.lowCnt = '0;
         s_nxt.active = 1'b0;
      end else if (s_r.lowCnt != CW'(RESET_MIN_CYC)) begin
         s_nxt.lowCnt = s_r.lowCnt + CW'(1);
      end else begin
         s_nxt.active = 1'b1;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_r <= '{sync1: 1'b1, sync2: 1'b1, lowCnt: '0, active: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign ctl.pinResetActive = s_r.active;

   resetMinLow_a: assert property (@(posedge clock) disable iff (rst)
      $rose(s_r.active) |-> $past(s_r.lowCnt) == CW'(RESET_MIN_CYC) && !$past(s_r.sync2))
      else $error("pin reset taken before minimum low time");

endmodule

// ==== design/t1d_mode_settle.sv ====
`timescale 1ns/1ps
module t1d_mode_settle
   import t1d_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // core side
   t1d_ctl_if.ms ctl
);
   import t1d_pkg::*;

   localparam int CW = $clog2(SETTLE_CYC + 1);

   typedef enum logic [2:0] {
      E1_MODE = 3'b001,
      SETTLE = 3'b010,
      T1_MODE = 3'b100
   } t1d_mode_t;

   typedef struct packed {
      t1d_mode_t mode;
      logic [CW-1:0] cnt;
      logic load;
   } t1d_ms_state_t;

   t1d_ms_state_t s_r, s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.load = 1'b0;
      if (ctl.pinResetActive || !ctl.modeSelect) begin
         s_nxt.mode = E1_MODE;
         s_nxt.cnt = '0;
      end else begin
         unique case (s_r.mode)
            E1_MODE: begin
               s_nxt.mode = SETTLE;
               s_nxt.cnt = '0;
            end
            SETTLE: begin
               // the load flag rises with T1 mode after the last settle count, keeping within the bound
               if (s_r.cnt == CW'(SETTLE_CYC - 1)) begin
                  s_nxt.mode = T1_MODE;
                  s_nxt.load = 1'b1;
               end else begin
                  s_nxt.cnt = s_r.cnt + CW'(1);
               end
            end
            T1_MODE: begin
               s_nxt.mode = T1_MODE;
            end
            default: begin
               s_nxt.mode = E1_MODE;
            end
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_r <= '{mode: E1_MODE, cnt: '0, load: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign ctl.t1Active = (s_r.mode == T1_MODE);
   assign ctl.settling = (s_r.mode == SETTLE);
   assign ctl.loadDefaults = s_r.load;

   sequence settleStart_s;
      $rose(ctl.settling);
   endsequence

   sequence settleDone_s;
      ctl.loadDefaults && ctl.t1Active;
   endsequence

   sequence settleAbort_s;
      ctl.pinResetActive || !ctl.modeSelect;
   endsequence

   // the settle lasts 1000 cycles unless the mode bit drops or the pin resets
   settleBound_a: assert property (@(posedge clock) disable iff (rst)
      settleStart_s |-> ##[1:1000] (settleDone_s or settleAbort_s))
      else $error("mode switch did not settle in time");

   settleExact_a: assert property (@(posedge clock) disable iff (rst)
      $rose(ctl.loadDefaults) |-> $past(ctl.settling) && $past(s_r.cnt) == CW'(SETTLE_CYC - 1))
      else $error("defaults applied at wrong settle count");

   e1Return_a: assert property (@(posedge clock) disable iff (rst)
      !ctl.modeSelect |=> !ctl.t1Active && !ctl.settling)
      else $error("T1 mode kept after mode select cleared");

endmodule

// ==== testbench/test_t1_mode_default_configuration.sv ====
`timescale 1ns/1ps
module test_t1_mode_default_configuration;
   import t1d_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic hwResetInN = 1'b1;
   logic wrEn = 1'b0;
   logic [5:0] wrIdx = 6'h00;
   logic [7:0] wrData = 8'h00;
   logic [5:0] rdIdx = 6'h00;
   logic [3:0] txMfPortIn = 4'hF;
   logic [7:0] rdData;
   t1d_pkg::t1d_bank_t cfgBank;
   logic t1Active, settling, inPinReset, outputsEnabled, txLineHighZ;
   logic mfSyncEnabled, mfSyncDetect, polarityMisuse, syncPortConflict;
   logic [1:0] mfSyncPort;
   logic [7:0] expTab [0:57];
   int nErrors = 0;
   int totalChecks = 0;
   int cnt;

   t1d_config_bank u_dut (.clock(clock), .rst(rst), .hwResetInN(hwResetInN), .wrEn(wrEn), .wrIdx(wrIdx),
      .wrData(wrData), .rdIdx(rdIdx), .rdData(rdData), .cfgBank(cfgBank), .t1Active(t1Active),
      .settling(settling), .inPinReset(inPinReset), .outputsEnabled(outputsEnabled),
      .txLineHighZ(txLineHighZ), .txMfPortIn(txMfPortIn), .mfSyncEnabled(mfSyncEnabled),
      .mfSyncPort(mfSyncPort), .mfSyncDetect(mfSyncDetect), .polarityMisuse(polarityMisuse),
      .syncPortConflict(syncPortConflict));

   always #10 clock = ~clock;

   task automatic finish_test();
      $display("checks %0d mismatches %0d", totalChecks, nErrors);
      if (nErrors == 0 && totalChecks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      totalChecks++;
      if (got !== exp) begin
         nErrors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      totalChecks++;
      if (got !== exp) begin
         nErrors++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      @(posedge clock);
      wrEn <= 1'b1;
      wrIdx <= idx;
      wrData <= d;
      @(posedge clock);
      wrEn <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
      @(posedge clock);
      rdIdx <= idx;
      @(posedge clock);
      @(negedge clock);
      chk8($sformatf("rdData[%0d]", idx), exp, rdData);
   endtask

   // settle a few cycles so registered status has caught up with the bank
   task automatic idle(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask

   task automatic chkBank(input logic [7:0] v57);
      logic [7:0] e;
      for (int i = 0; i < 58; i++) begin
         e = (i == 57) ? v57 : expTab[i];
         rd(6'(i), e);
         chk8($sformatf("cfgBank[%0d]", i), e, cfgBank[i]);
      end
   endtask

   task automatic mfStatus(input logic en, input logic [1:0] port, input logic det, input logic mis,
                           input logic conf);
      idle(4);
      chk1("mfSyncEnabled", en, mfSyncEnabled);
      chk8("mfSyncPort", {6'h00, port}, {6'h00, mfSyncPort});
      chk1("mfSyncDetect", det, mfSyncDetect);
      chk1("polarityMisuse", mis, polarityMisuse);
      chk1("syncPortConflict", conf, syncPortConflict);
   endtask

   initial begin
      for (int i = 0; i < 58; i++) begin
         expTab[i] = 8'h00;
      end
      expTab[7] = 8'h9C;
      expTab[9] = 8'h9C;
      expTab[21] = 8'h40;
      expTab[22] = 8'h03;
      expTab[23] = 8'h7B;
      for (int i = 24; i < 30; i++) begin
         expTab[i] = 8'hFF;
      end
      expTab[43] = 8'hFD;
      expTab[44] = 8'hFF;
      expTab[45] = 8'hFF;
      expTab[46] = 8'hFF;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      idle(2);

      chk1("t1Active", 1'b0, t1Active);
      chk1("outputsEnabled", 1'b1, outputsEnabled);
      chk1("txLineHighZ", 1'b1, txLineHighZ);
      chkBank(8'h00);
      $display("test reset_defaults done");

      wr(6'h00, 8'h5A);
      wr(6'h38, 8'hA5);
      wr(6'h3C, 8'h33);
      rd(6'h00, 8'h5A);
      rd(6'h38, 8'hA5);
      rd(6'h3C, 8'h00);
      wr(6'h17, 8'h3B);
      idle(3);
      chk1("txLineHighZ", 1'b0, txLineHighZ);
      wr(6'h17, 8'h7B);
      idle(3);
      chk1("txLineHighZ", 1'b1, txLineHighZ);
      $display("test access done");

      // polarity bit without a multiframe sync port is flagged only
      wr(6'h26, 8'h01);
      mfStatus(1'b0, 2'h0, 1'b0, 1'b1, 1'b0);
      wr(6'h24, 8'h01);
      txMfPortIn <= 4'h4;
      mfStatus(1'b1, 2'h2, 1'b1, 1'b0, 1'b1);
      txMfPortIn <= 4'hB;
      mfStatus(1'b1, 2'h2, 1'b0, 1'b0, 1'b1);
      wr(6'h22, 8'h02);
      wr(6'h23, 8'h02);
      wr(6'h25, 8'h02);
      mfStatus(1'b1, 2'h2, 1'b0, 1'b0, 1'b0);
      wr(6'h22, 8'h01);
      wr(6'h26, 8'h00);
      txMfPortIn <= 4'hE;
      mfStatus(1'b1, 2'h0, 1'b1, 1'b0, 1'b0);
      txMfPortIn <= 4'hF;
      mfStatus(1'b1, 2'h0, 1'b0, 1'b0, 1'b0);
      $display("test multiframe_sync done");

      wr(6'h39, 8'h01);
      for (cnt = 0; cnt < 10 && settling !== 1'b1; cnt++) begin
         @(posedge clock);
      end
      chk1("settling", 1'b1, settling);
      wr(6'h01, 8'h77);
      for (cnt = 2; cnt < 1100 && t1Active !== 1'b1; cnt++) begin
         @(posedge clock);
      end
      chk1("settleWithin1000", 1'b1, cnt <= 1000);
      idle(1);
      chk1("t1Active", 1'b1, t1Active);
      chkBank(8'h01);
      wr(6'h39, 8'h00);
      idle(1);
      chk1("t1Active", 1'b0, t1Active);
      $display("test mode_switch done");

      wr(6'h00, 8'h5A);
      @(posedge clock);
      hwResetInN <= 1'b0;
      repeat (100) @(posedge clock);
      hwResetInN <= 1'b1;
      idle(6);
      chk1("inPinReset", 1'b0, inPinReset);
      chk8("cfgBank[0]", 8'h5A, cfgBank[0]);
      hwResetInN <= 1'b0;
      repeat (520) @(posedge clock);
      wr(6'h01, 8'h66);
      idle(2);
      chk1("inPinReset", 1'b1, inPinReset);
      chk1("outputsEnabled", 1'b0, outputsEnabled);
      chk1("txLineHighZ", 1'b1, txLineHighZ);
      chk8("cfgBank[0]", 8'h00, cfgBank[0]);
      chk8("cfgBank[1]", 8'h00, cfgBank[1]);
      @(posedge clock);
      hwResetInN <= 1'b1;
      for (cnt = 0; cnt < 10 && inPinReset !== 1'b0; cnt++) begin
         @(posedge clock);
      end
      idle(2);
      chk1("inPinReset", 1'b0, inPinReset);
      chk1("outputsEnabled", 1'b1, outputsEnabled);
      chkBank(8'h00);
      $display("test pin_reset done");
      finish_test();
   end

   // whole sequence needs roughly 2100 cycles
   initial begin
      repeat (20000) @(posedge clock);
      nErrors++;
      $display("[FAIL] watchdog expected completion seen timeout");
      finish_test();
   end
endmodule
